// [rtes_ctr.sv]
// One event counter with optional edge detect on the any-cause level
`timescale 1ns/1ns
`default_nettype none
module rtes_ctr #(
  parameter int CNT_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic edge_i,
  input wire rtes_pkg::rtes_qual_s q_i,
  input wire logic wr_i,
  input wire logic [3:0] wsel_i,
  input wire logic [rtes_pkg::DAT_W-1:0] wdat_i,
  output logic [CNT_W-1:0] cnt_o
);
  import rtes_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic prev;
  } rtes_ctr_s;

  rtes_ctr_s s_r;
  rtes_ctr_s s_nxt;

  always_comb begin
    logic any;
    logic [DAT_W-1:0] wide;
    s_nxt = s_r;
    s_nxt.prev = q_i.any_lvl;
    // Edge mode turns a flush duration into a flush occurrence count
    any = q_i.any_lvl & ~(edge_i & s_r.prev);
    wide = wb_merge(DAT_W'(s_r.cnt), wdat_i, wsel_i, CNT_WR_MASK);
    // Software preset wins over counting in the same cycle
    if (wr_i) begin
      s_nxt.cnt = wide[CNT_W-1:0];
    end else if (en_i) begin
      s_nxt.cnt = s_r.cnt + CNT_W'(q_i.inc) + CNT_W'(any);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cnt_o = s_r.cnt;
endmodule
`default_nettype wire

// [rtes_pkg.sv]
// Constants, carriers and helpers for the retirement event select block
package rtes_pkg;
  localparam int NSEL = 4;
  localparam int NCTR = 6;
  localparam int INC_W = 3;
  localparam int ADDR_W = 8;
  localparam int DAT_W = 32;
  localparam logic [6:0] EVT_FP_ASSIST = 7'h03;
  localparam logic [6:0] EVT_PIPE_FLUSH = 7'h02;
  localparam logic [6:0] EVT_INSTR_DONE = 7'h07;
  localparam logic [2:0] CFG_SEL_RETIRE = 3'h5;
  localparam logic [2:0] CFG_SEL_INSTR = 3'h4;
  localparam int SEL_CODE_LSB = 25;
  localparam int SEL_MASK_LSB = 9;
  localparam int CFG_SEL_LSB = 13;
  localparam int CFG_EN_BIT = 12;
  localparam int CFG_EDGE_BIT = 24;
  localparam int MB_STACK_UNDERFLOW = 0;
  localparam int MB_STACK_OVERFLOW = 1;
  localparam int MB_OUTPUT_OVERFLOW = 2;
  localparam int MB_OUTPUT_UNDERFLOW = 3;
  localparam int MB_INPUT_OPERAND = 4;
  localparam int MB_FLUSH_ANY = 0;
  localparam int MB_MEMORY_ORDER = 2;
  localparam int MB_SELF_MOD_CODE = 6;
  localparam int MB_VALID_PATH = 0;
  localparam int MB_BOGUS = 1;
  localparam logic [ADDR_W-1:0] ADDR_SEL_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CFG_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CNT_BASE = 8'h28;
  localparam logic [DAT_W-1:0] SEL_WR_MASK = 32'hFFFF_FE00;
  localparam logic [DAT_W-1:0] CFG_WR_MASK = 32'h0100_F000;
  localparam logic [DAT_W-1:0] CNT_WR_MASK = 32'hFFFF_FFFF;
  localparam logic [NCTR-1:0] CTR_GROUP_B = 6'h2C;

  typedef struct packed {
    logic [4:0] fp_assist;
    logic flush_any;
    logic memory_order_flush;
    logic self_mod_code_flush;
    logic [1:0] valid_path_instr;
    logic [1:0] bogus_instr;
  } rtes_evt_s;

  typedef struct packed {
    logic [INC_W-1:0] inc;
    logic any_lvl;
  } rtes_qual_s;

  typedef struct packed {
    logic [NSEL-1:0][DAT_W-1:0] sel;
    logic [NCTR-1:0][DAT_W-1:0] cfg;
    logic ack;
    logic [DAT_W-1:0] dat;
  } rtes_regs_s;

  function automatic logic [DAT_W-1:0] wb_merge(
    input logic [DAT_W-1:0] old, input logic [DAT_W-1:0] dat,
    input logic [3:0] sel, input logic [DAT_W-1:0] keep);
    logic [DAT_W-1:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) m[b*8 +: 8] = 8'hFF;
    end
    m = m & keep;
    return (old & ~m) | (dat & m);
  endfunction

  function automatic logic [ADDR_W-1:0] reg_addr(
    input logic [ADDR_W-1:0] base, input int idx);
    return base + ADDR_W'(idx * 4);
  endfunction

  function automatic logic [INC_W-1:0] ones_cnt(input logic [4:0] v);
    logic [INC_W-1:0] n;
    n = '0;
    for (int b = 0; b < 5; b++) begin
      n = n + INC_W'(v[b]);
    end
    return n;
  endfunction
endpackage

// [rtes_qual.sv]
// Event qualification for one retirement-unit selection control
`timescale 1ns/1ns
`default_nettype none
module rtes_qual #(
  parameter bit INSTR_CTRL = 1'b0
) (
  input wire logic [rtes_pkg::DAT_W-1:0] sel_i,
  input wire rtes_pkg::rtes_evt_s evt_i,
  output var rtes_pkg::rtes_qual_s q_o
);
  import rtes_pkg::*;

  always_comb begin
    logic [6:0] code;
    logic [15:0] mask;
    code = sel_i[SEL_CODE_LSB +: 7];
    mask = sel_i[SEL_MASK_LSB +: 16];
    q_o = '0;
    // Mismatched code or empty mask leaves the control silent
    if (INSTR_CTRL) begin
      if (code == EVT_INSTR_DONE) begin
        // Completions, not starts, arrive on these counts
        q_o.inc = (mask[MB_VALID_PATH] ? INC_W'(evt_i.valid_path_instr)
                                       : '0)
                + (mask[MB_BOGUS] ? INC_W'(evt_i.bogus_instr) : '0);
      end
    end else begin
      unique case (code)
        EVT_FP_ASSIST: begin
          q_o.inc = ones_cnt(evt_i.fp_assist & mask[4:0]);
        end
        EVT_PIPE_FLUSH: begin
          q_o.any_lvl = mask[MB_FLUSH_ANY] & evt_i.flush_any;
          q_o.inc = INC_W'(mask[MB_MEMORY_ORDER] &
                           evt_i.memory_order_flush)
                  + INC_W'(mask[MB_SELF_MOD_CODE] &
                           evt_i.self_mod_code_flush);
        end
        default: q_o = '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// [rtes_top.sv]
// Retirement event select: Wishbone registers, qualifiers and counters
//
// Behaviour
// - With the assist event chosen, mask bit 0 counts stack underflow.
// - The assist event is code 03H, config select 05H, controls 2 and 3 only, bit 1 counts stack overflow.
// - Assist mask bit 2 counts output overflow and bit 3 output underflow.
// - Assist mask bit 4 counts input operand assists; code is at [31:25], mask at [24:9].
// - Code 02H counts by the chosen mask bit while the whole pipeline flushes.
// - Flush mask bit 0 counts cycles in which the machine flushes for any cause.
// - Flush mask bit 2 counts once per memory-ordering flush.
// - Flush mask bit 6 counts once per self-modifying-code flush.
// - Flush event uses select 05H: counters 12,13,16 via control 2, 14,15,17 via 3.
// - Code 07H counts instructions completing and retiring each cycle.
// - Completion mask bit 0 counts non-bogus and bit 1 bogus instructions.
// - Completions use select 04H: counters 12,13,16 via control 0, 14,15,17 via 1.
// - The completion count reflects finished instructions, not starts.
`timescale 1ns/1ns
`default_nettype none
module rtes_top #(
  parameter int CNT_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rtes_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [rtes_pkg::DAT_W-1:0] wb_dat_i,
  output logic [rtes_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire rtes_pkg::rtes_evt_s evt_i
);
  import rtes_pkg::*;

  if (CNT_W < 8 || CNT_W > DAT_W) begin : g_bad_width
    $error("CNT_W must lie between 8 and 32");
  end

  rtes_regs_s s_r;
  rtes_regs_s s_nxt;
  logic [NCTR-1:0] cnt_wr;
  logic [CNT_W-1:0] cnt [NCTR];
  rtes_qual_s q [NSEL];
  rtes_qual_s qsel [NCTR];
  logic [6:0] code [NSEL];
  logic [15:0] mask [NSEL];

  // Register access; events come from core logic on this clock
  always_comb begin
    logic req;
    logic [DAT_W-1:0] rd;
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    cnt_wr = '0;
    rd = '0;
    // The ack term keeps a held request from being taken twice
    req = wb_cyc_i & wb_stb_i & ~s_r.ack;
    for (int i = 0; i < NSEL; i++) begin
      if (wb_adr_i == reg_addr(ADDR_SEL_BASE, i)) begin
        rd = s_r.sel[i];
        if (req && wb_we_i) begin
          s_nxt.sel[i] = wb_merge(s_r.sel[i], wb_dat_i, wb_sel_i,
                                  SEL_WR_MASK);
        end
      end
    end
    for (int i = 0; i < NCTR; i++) begin
      if (wb_adr_i == reg_addr(ADDR_CFG_BASE, i)) begin
        rd = s_r.cfg[i];
        if (req && wb_we_i) begin
          s_nxt.cfg[i] = wb_merge(s_r.cfg[i], wb_dat_i, wb_sel_i,
                                  CFG_WR_MASK);
        end
      end
      if (wb_adr_i == reg_addr(ADDR_CNT_BASE, i)) begin
        rd = DAT_W'(cnt[i]);
        cnt_wr[i] = req & wb_we_i;
      end
    end
    // Unmapped addresses still answer, reading zero
    if (req) begin
      s_nxt.ack = 1'b1;
      s_nxt.dat = rd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;

  // Controls 0 and 1 serve completions; 2 and 3 serve assists and flushes
  for (genvar j = 0; j < NSEL; j++) begin : g_sel
    assign code[j] = s_r.sel[j][SEL_CODE_LSB +: 7];
    assign mask[j] = s_r.sel[j][SEL_MASK_LSB +: 16];
    rtes_qual #(
      .INSTR_CTRL(j < 2)
    ) u_qual (
      .sel_i(s_r.sel[j]),
      .evt_i(evt_i),
      .q_o(q[j])
    );
  end

  for (genvar i = 0; i < NCTR; i++) begin : g_ctr
    localparam int GB = CTR_GROUP_B[i] ? 1 : 0;
    always_comb begin
      // Any other select value leaves the counter without a source
      case (s_r.cfg[i][CFG_SEL_LSB +: 3])
        CFG_SEL_INSTR: qsel[i] = q[GB];
        CFG_SEL_RETIRE: qsel[i] = q[2 + GB];
        default: qsel[i] = '0;
      endcase
    end
    rtes_ctr #(
      .CNT_W(CNT_W)
    ) u_ctr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(s_r.cfg[i][CFG_EN_BIT]),
      .edge_i(s_r.cfg[i][CFG_EDGE_BIT]),
      .q_i(qsel[i]),
      .wr_i(cnt_wr[i]),
      .wsel_i(wb_sel_i),
      .wdat_i(wb_dat_i),
      .cnt_o(cnt[i])
    );
  end

  stack_underflow_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (code[2] == EVT_FP_ASSIST && mask[2] == 16'h0001) |->
      q[2].inc == 3'(evt_i.fp_assist[0]))
    else $error("stack underflow assist not counted");

  assist_controls_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (code[0] == EVT_FP_ASSIST |-> q[0] == '0) and
    (code[1] == EVT_FP_ASSIST |-> q[1] == '0))
    else $error("assist event counted on a completion control");

  stack_overflow_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (code[2] == EVT_FP_ASSIST && mask[2] == 16'h0002) |->
      q[2].inc == 3'(evt_i.fp_assist[1]))
    else $error("stack overflow assist miscounted");

  output_assist_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (code[3] == EVT_FP_ASSIST && (mask[3] == 16'h0004 ||
     mask[3] == 16'h0008 || mask[3] == 16'h000C)) |->
      q[3].inc == 3'(evt_i.fp_assist[2] & mask[3][2]) +
                  3'(evt_i.fp_assist[3] & mask[3][3]))
    else $error("output assist miscounted");

  // Raw register value pins down where code and mask fields sit
  input_assist_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (s_r.sel[2] == 32'h0600_2000) |->
      q[2].inc == 3'(evt_i.fp_assist[4]))
    else $error("input operand assist field placement wrong");

  flush_select_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (code[3] != EVT_PIPE_FLUSH && code[3] != EVT_FP_ASSIST) |->
      q[3] == '0)
    else $error("flush control counts without its code");

  flush_any_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (code[2] == EVT_PIPE_FLUSH && mask[2][MB_FLUSH_ANY]) |->
      q[2].any_lvl == evt_i.flush_any)
    else $error("any-cause flush level not followed");

  mem_order_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (s_r.cfg[0][CFG_EN_BIT] &&
     s_r.cfg[0][CFG_SEL_LSB +: 3] == CFG_SEL_RETIRE &&
     code[2] == EVT_PIPE_FLUSH && mask[2] == 16'h0004 &&
     evt_i.memory_order_flush && !cnt_wr[0])
    |=> cnt[0] - $past(cnt[0]) == CNT_W'(1))
    else $error("memory order flush not counted once");

  self_mod_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (code[3] == EVT_PIPE_FLUSH && mask[3] == 16'h0040) |->
      q[3].inc == 3'(evt_i.self_mod_code_flush))
    else $error("self-modifying code flush miscounted");

  flush_routing_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (s_r.cfg[2][CFG_SEL_LSB +: 3] == CFG_SEL_RETIRE) |->
      qsel[2] == q[3])
    else $error("flush control routed to wrong counter");

  flush_route_low_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (s_r.cfg[4][CFG_SEL_LSB +: 3] == CFG_SEL_RETIRE) |->
      qsel[4] == q[2])
    else $error("flush control routed to wrong counter");

  completed_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (code[0] == EVT_INSTR_DONE && mask[0][1:0] == 2'h2) |->
      q[0].inc == 3'(evt_i.bogus_instr))
    else $error("completed instructions miscounted");

  bogus_split_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (code[1] == EVT_INSTR_DONE && mask[1][1:0] == 2'h1) |->
      q[1].inc == 3'(evt_i.valid_path_instr))
    else $error("bogus instructions leaked into non-bogus count");

  instr_routing_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (s_r.cfg[3][CFG_SEL_LSB +: 3] == CFG_SEL_INSTR) |->
      qsel[3] == q[1])
    else $error("completion control routed to wrong counter");

  completion_sum_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (s_r.cfg[1][CFG_EN_BIT] &&
     s_r.cfg[1][CFG_SEL_LSB +: 3] == CFG_SEL_INSTR &&
     code[0] == EVT_INSTR_DONE && !cnt_wr[1])
    |=> cnt[1] - $past(cnt[1]) == CNT_W'($past(q[0].inc)))
    else $error("counter step differs from completions");

  idle_counter_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (!s_r.cfg[5][CFG_EN_BIT] && !cnt_wr[5]) |=> $stable(cnt[5]))
    else $error("disabled counter moved");

  empty_mask_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (mask[2] == 16'h0000) |-> q[2] == '0)
    else $error("counted with no mask bit set");
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking testbench for the retirement event select block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rtes_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [DAT_W-1:0] wdat = '0;
  logic [3:0] sel = 4'h0;
  logic [DAT_W-1:0] rdat;
  logic ack;
  rtes_evt_s evt = '0;
  int fail_count = 0;
  int samples_checked = 0;
  int test_no = 0;

  rtes_top #(.CNT_W(32)) u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .evt_i(evt)
  );

  always #5 clk_i = ~clk_i;

  task automatic results();
    $display("Counts: %0d checked, %0d mismatches", samples_checked,
      fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [DAT_W-1:0] got,
    input logic [DAT_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; a missing ack is left to the watchdog
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DAT_W-1:0] d, input logic [3:0] be,
    output logic [DAT_W-1:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= be;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a,
    input logic [DAT_W-1:0] d, input logic [3:0] be = 4'hF);
    logic [DAT_W-1:0] q;
    xfer(1'b1, a, d, be, q);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a,
    input logic [DAT_W-1:0] exp);
    logic [DAT_W-1:0] q;
    xfer(1'b0, a, '0, 4'hF, q);
    chk(q, exp);
  endtask

  // Program one control and one counter, apply events for n cycles, read
  task automatic run(input int s, input logic [6:0] code, input int mb,
    input int c, input logic [2:0] cs, input logic ed,
    input logic [11:0] ev, input int n, input logic [DAT_W-1:0] exp);
    wr(ADDR_SEL_BASE + 8'(s * 4), (32'(code) << 25) | (32'h1 << (mb + 9)));
    wr(ADDR_CFG_BASE + 8'(c * 4),
      (32'(cs) << 13) | 32'h0000_1000 | (32'(ed) << 24));
    wr(ADDR_CNT_BASE + 8'(c * 4), 32'h0);
    @(posedge clk_i);
    evt <= rtes_evt_s'(ev);
    repeat (n) @(posedge clk_i);
    evt <= '0;
    repeat (2) @(posedge clk_i);
    rd_chk(ADDR_CNT_BASE + 8'(c * 4), exp);
    test_no++;
    $display("Test %0d done", test_no);
  endtask

  initial begin
    #200000;
    fail_count++;
    results();
  end

  // Event bits, msb first: assists[11:7], any[6], mem[5], smc[4],
  // valid[3:2], bogus[1:0]
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h28, 32'h0);
    wr(8'h04, 32'hFFFF_FFFF);
    rd_chk(8'h04, 32'hFFFF_FE00);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd_chk(8'h1C, 32'h0100_F000);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0);
    // Only the enabled byte lane may change
    wr(8'h00, 32'hFFFF_FFFF, 4'h8);
    rd_chk(8'h00, 32'hFF00_0000);
    $display("Test register access done");
    // Each assist bit alone must pick out one of five simultaneous pulses
    run(2, 7'h03, 0, 0, 3'h5, 1'b0, 12'hF80, 1, 32'h1);
    run(2, 7'h03, 1, 1, 3'h5, 1'b0, 12'hF80, 2, 32'h2);
    run(3, 7'h03, 2, 2, 3'h5, 1'b0, 12'hF80, 1, 32'h1);
    run(3, 7'h03, 3, 3, 3'h5, 1'b0, 12'hF80, 3, 32'h3);
    run(2, 7'h03, 4, 4, 3'h5, 1'b0, 12'hF80, 1, 32'h1);
    run(2, 7'h03, 4, 4, 3'h5, 1'b0, 12'h780, 2, 32'h0);
    // Assist code on a completion control must not count
    run(0, 7'h03, 0, 0, 3'h4, 1'b0, 12'hF8E, 2, 32'h0);
    // Flush causes; cause pulses held high count once per cycle
    run(3, 7'h02, 0, 5, 3'h5, 1'b0, 12'h050, 4, 32'h4);
    run(3, 7'h02, 0, 5, 3'h5, 1'b1, 12'h050, 4, 32'h1);
    run(2, 7'h02, 2, 0, 3'h5, 1'b0, 12'h060, 3, 32'h3);
    run(2, 7'h02, 6, 1, 3'h5, 1'b0, 12'h060, 3, 32'h0);
    run(3, 7'h02, 6, 2, 3'h5, 1'b0, 12'h050, 2, 32'h2);
    run(3, 7'h02, 2, 3, 3'h5, 1'b1, 12'h060, 2, 32'h2);
    run(2, 7'h02, 0, 4, 3'h5, 1'b0, 12'h040, 2, 32'h2);
    // Flush code on select 04H routing must not count
    run(1, 7'h02, 0, 2, 3'h4, 1'b0, 12'h040, 2, 32'h0);
    // Completions: counts per cycle, each mask bit its own kind
    run(0, 7'h07, 0, 1, 3'h4, 1'b0, 12'h00E, 2, 32'h6);
    run(0, 7'h07, 1, 4, 3'h4, 1'b0, 12'h00E, 2, 32'h4);
    run(1, 7'h07, 0, 5, 3'h4, 1'b0, 12'h00D, 3, 32'h9);
    run(1, 7'h07, 1, 3, 3'h4, 1'b0, 12'h00D, 1, 32'h1);
    // Control 0 does not feed the second counter group; control 1
    // still counts bogus only, so no bogus completions are applied
    run(0, 7'h07, 0, 2, 3'h4, 1'b0, 12'h00C, 2, 32'h0);
    // Select 05H counters ignore completion code
    run(2, 7'h07, 0, 0, 3'h5, 1'b0, 12'h00E, 2, 32'h0);
    results();
  end
endmodule
`default_nettype wire
